// file: logic/dcoc_map.svh
// Constants of the dc offset calibration controller
`ifndef DCOC_MAP_SVH
`define DCOC_MAP_SVH

// Reference clock rate in kHz
`define DCOC_REF_CLK_KHZ 125000

// Internal oscillator frequency per trim code, in kHz
`define DCOC_OSC_KHZ_0 300
`define DCOC_OSC_KHZ_1 500
`define DCOC_OSC_KHZ_2 700
`define DCOC_OSC_KHZ_3 900
`define DCOC_OSC_KHZ_4 1100
`define DCOC_OSC_KHZ_5 1300
`define DCOC_OSC_KHZ_6 1500
`define DCOC_OSC_KHZ_7 1800

// Reset values
`define DCOC_OSC_TRIM_RST 3'h3
`define DCOC_DAC_HALF 8'h80

// Calibration length in calibration clock cycles
`define DCOC_CAL_CYCLES 9

// Calibration clock divide ratio per divider code
`define DCOC_DIV_0 1
`define DCOC_DIV_1 2
`define DCOC_DIV_2 8
`define DCOC_DIV_3 32
`define DCOC_DIV_4 64
`define DCOC_DIV_5 256
`define DCOC_DIV_6 512
`define DCOC_DIV_7 1024

// Readback word field positions
`define DCOC_RB_Q_LSB 16
`define DCOC_RB_I_LSB 24

`endif

// file: logic/dcoc_pkg.sv
// Types of the dc offset calibration controller
package dcoc_pkg;

  typedef enum logic [1:0] {
    DCOC_IDLE = 2'b00,
    DCOC_LOAD = 2'b01,
    DCOC_STEP = 2'b10
  } dcoc_state_type;

  // Static configuration from the host
  typedef struct packed {
    logic cal_clk_sel;
    logic [2:0] clk_div_code;
    logic [1:0] correction_dac_range;
    logic auto_mode;
    logic detector_resistor_bypass;
    logic detector_capacitor_bypass;
  } dcoc_cfg_type;

  typedef struct packed {
    dcoc_state_type state;
    logic calibration_start;
    logic [2:0] bit_idx;
    logic [7:0] cal_i;
    logic [7:0] cal_q;
    logic [7:0] man_i;
    logic [7:0] man_q;
    logic [2:0] osc_trim;
    dcoc_cfg_type cfg;
    logic spi_s1;
    logic spi_s2;
    logic spi_s3;
    logic [1:0] det_s1;
    logic [1:0] det_s2;
    logic [7:0] dac_i;
    logic [7:0] dac_q;
  } dcoc_main_type;

  typedef struct packed {
    logic [15:0] cnt;
    logic tick;
  } dcoc_osc_type;

  typedef struct packed {
    logic [10:0] cnt;
    logic tick;
  } dcoc_div_type;

endpackage

// file: logic/dcoc_osc.sv
// Internal trimmable oscillator modelled as an enable pulse generator
`timescale 1ns/1ps
`include "dcoc_map.svh"

module dcoc_osc
  import dcoc_pkg::*;
#(
  parameter int REF_KHZ = `DCOC_REF_CLK_KHZ
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Control
  input wire logic [2:0] osc_trim,
  // Output
  output logic osc_tick
);

  dcoc_osc_type s_q;
  dcoc_osc_type s_d;

  // Reference cycles per oscillator period for a trim code
  function automatic logic [15:0] period(input logic [2:0] t);
    int khz;
    case (t)
      3'h0: khz = `DCOC_OSC_KHZ_0;
      3'h1: khz = `DCOC_OSC_KHZ_1;
      3'h2: khz = `DCOC_OSC_KHZ_2;
      3'h3: khz = `DCOC_OSC_KHZ_3;
      3'h4: khz = `DCOC_OSC_KHZ_4;
      3'h5: khz = `DCOC_OSC_KHZ_5;
      3'h6: khz = `DCOC_OSC_KHZ_6;
      default: khz = `DCOC_OSC_KHZ_7;
    endcase
    return 16'(REF_KHZ / khz);
  endfunction

  // Count one period, pulse at its end
  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    if (s_q.cnt >= 16'(period(osc_trim) - 16'h1)) begin
      s_d.cnt = 16'h0;
      s_d.tick = 1'b1;
    end else begin
      s_d.cnt = 16'(s_q.cnt + 16'h1);
    end
  end

  // State register
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign osc_tick = s_q.tick;

  a_osc_tick_period: assert property (@(posedge ref_clk) disable iff (!reset_n)
    osc_tick && $stable(osc_trim) |-> $past(s_q.cnt) >= 16'(period(osc_trim) - 16'h1))
    else $error("oscillator pulse before period end");

endmodule

// file: logic/dcoc_clkdiv.sv
// Calibration clock divider working on enable pulses
`timescale 1ns/1ps
`include "dcoc_map.svh"

module dcoc_clkdiv
  import dcoc_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Control
  input wire logic [2:0] div_code,
  input wire logic restart,
  // Pulses
  input wire logic in_tick,
  output logic out_tick
);

  dcoc_div_type s_q;
  dcoc_div_type s_d;
  logic [10:0] ratio;

  // Ratio per divider code
  always_comb begin
    case (div_code)
      3'h0: ratio = 11'(`DCOC_DIV_0);
      3'h1: ratio = 11'(`DCOC_DIV_1);
      3'h2: ratio = 11'(`DCOC_DIV_2);
      3'h3: ratio = 11'(`DCOC_DIV_3);
      3'h4: ratio = 11'(`DCOC_DIV_4);
      3'h5: ratio = 11'(`DCOC_DIV_5);
      3'h6: ratio = 11'(`DCOC_DIV_6);
      default: ratio = 11'(`DCOC_DIV_7);
    endcase
  end

  // One output pulse per ratio input pulses; restart clears the phase
  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    if (restart) begin
      s_d.cnt = 11'h0;
    end else if (in_tick) begin
      if (s_q.cnt >= 11'(ratio - 11'h1)) begin
        s_d.cnt = 11'h0;
        s_d.tick = 1'b1;
      end else begin
        s_d.cnt = 11'(s_q.cnt + 11'h1);
      end
    end
  end

  // State register
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign out_tick = s_q.tick;

  a_div_ratio_end: assert property (@(posedge ref_clk) disable iff (!reset_n)
    out_tick && $past(!restart) |-> $past(in_tick) && $past(s_q.cnt) >= 11'($past(ratio) - 11'h1))
    else $error("divider pulse without full ratio");

endmodule

// file: logic/dcoc_autocal.sv
// Dc offset calibration controller: clock select, sequencer and DAC registers
`timescale 1ns/1ps
`include "dcoc_map.svh"

// Overview of operation
// - Calibration clock comes from the internal oscillator when select is 1, else serial clock.
// - Three-bit trim picks oscillator frequency 300 kHz up to 1.8 MHz.
// - Trim resets to the 900 kHz code, which suits calibration as is.
// - Two-bit range sets correction DAC full scale, 50 to 200 microamps.
// - Automatic mode drives the DACs from calibration registers, not host values.
// - Both calibration registers load half scale, 128, at start-up.
// - Writing start begins calibration; the start bit clears itself at the end.
// - Calibration codes, and the DACs in automatic mode, are held until a new calibration is started.
// - Two bits bypass the detector filter resistor and capacitor respectively.
// - A three-bit divider code divides the calibration clock, up to 1024.
// - Calibration takes nine calibration clock cycles times the divider ratio.
// - Readback shows Q in bits 16 to 23 and I in 24 to 31.
module dcoc_autocal
  import dcoc_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Host configuration
  input dcoc_cfg_type cfg_in,
  input wire logic osc_trim_wr,
  input wire logic [2:0] osc_trim_value,
  input wire logic cal_start_set,
  // Host manual correction values
  input wire logic manual_wr,
  input wire logic [7:0] i_channel_correction_value,
  input wire logic [7:0] q_channel_correction_value,
  // Pins from outside the clock domain
  input wire logic serial_clk,
  input wire logic det_i_high,
  input wire logic det_q_high,
  // Status
  output logic calibration_start,
  output logic [2:0] osc_trim,
  output logic [7:0] i_offset_readback,
  output logic [7:0] q_offset_readback,
  output logic [31:0] readback_word,
  // Analog controls
  output logic [7:0] dac_i_code,
  output logic [7:0] dac_q_code,
  output logic dac_range_bit0,
  output logic dac_range_bit1,
  output logic detector_resistor_bypass,
  output logic detector_capacitor_bypass
);

  localparam dcoc_main_type MAIN_RST = '{
    state: DCOC_IDLE,
    calibration_start: 1'b0,
    bit_idx: 3'h0,
    cal_i: `DCOC_DAC_HALF,
    cal_q: `DCOC_DAC_HALF,
    man_i: `DCOC_DAC_HALF,
    man_q: `DCOC_DAC_HALF,
    osc_trim: `DCOC_OSC_TRIM_RST,
    cfg: '0,
    spi_s1: 1'b0,
    spi_s2: 1'b0,
    spi_s3: 1'b0,
    det_s1: 2'h0,
    det_s2: 2'h0,
    dac_i: `DCOC_DAC_HALF,
    dac_q: `DCOC_DAC_HALF
  };

  dcoc_main_type s_q;
  dcoc_main_type s_d;
  logic osc_tick;
  logic serial_rise;
  logic src_tick;
  logic cal_en;
  logic [2:0] next_idx;

  // Internal oscillator
  dcoc_osc dcoc_osc_i (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .osc_trim(s_q.osc_trim),
    .osc_tick(osc_tick)
  );

  // Rising edge of the synchronised serial clock
  assign serial_rise = s_q.spi_s2 && !s_q.spi_s3;

  // Calibration clock source select
  assign src_tick = cfg_in.cal_clk_sel ? osc_tick : serial_rise;

  // Divider, restarted at each start so the first step gets a full period
  dcoc_clkdiv dcoc_clkdiv_i (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .div_code(cfg_in.clk_div_code),
    .restart(cal_start_set),
    .in_tick(src_tick),
    .out_tick(cal_en)
  );

  assign next_idx = 3'(s_q.bit_idx - 3'h1);

  // Next state: synchronisers, host writes, successive approximation
  always_comb begin
    s_d = s_q;
    // Pin synchronisers, first stage read only by the second
    s_d.spi_s1 = serial_clk;
    s_d.spi_s2 = s_q.spi_s1;
    s_d.spi_s3 = s_q.spi_s2;
    s_d.det_s1 = {det_q_high, det_i_high};
    s_d.det_s2 = s_q.det_s1;
    // Configuration copied to the analog side
    s_d.cfg = cfg_in;
    if (osc_trim_wr) begin
      s_d.osc_trim = osc_trim_value;
    end
    if (manual_wr) begin
      s_d.man_i = i_channel_correction_value;
      s_d.man_q = q_channel_correction_value;
    end
    // Sequencer; a high detector means the code overshoots, drop the bit
    case (s_q.state)
      DCOC_IDLE: begin
        s_d.bit_idx = 3'h0; // Calibration codes are held here
      end
      DCOC_LOAD: begin
        if (cal_en) begin
          s_d.cal_i = `DCOC_DAC_HALF;
          s_d.cal_q = `DCOC_DAC_HALF;
          s_d.bit_idx = 3'h7;
          s_d.state = DCOC_STEP;
        end
      end
      DCOC_STEP: begin
        if (cal_en) begin
          if (s_q.det_s2[0]) begin
            s_d.cal_i[s_q.bit_idx] = 1'b0;
          end
          if (s_q.det_s2[1]) begin
            s_d.cal_q[s_q.bit_idx] = 1'b0;
          end
          if (s_q.bit_idx == 3'h0) begin
            s_d.state = DCOC_IDLE;
            s_d.calibration_start = 1'b0;
          end else begin
            s_d.cal_i[next_idx] = 1'b1;
            s_d.cal_q[next_idx] = 1'b1;
            s_d.bit_idx = next_idx;
          end
        end
      end
      default: begin
        s_d.state = DCOC_IDLE;
      end
    endcase
    // A start write wins over the end-of-run clear and restarts a run
    if (cal_start_set) begin
      s_d.calibration_start = 1'b1;
      s_d.state = DCOC_LOAD;
    end
    // DAC drive source
    if (cfg_in.auto_mode) begin
      s_d.dac_i = s_d.cal_i;
      s_d.dac_q = s_d.cal_q;
    end else begin
      s_d.dac_i = s_d.man_i;
      s_d.dac_q = s_d.man_q;
    end
  end

  // State register; reset loads half scale and the 900 kHz trim
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      s_q <= MAIN_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs
  assign calibration_start = s_q.calibration_start;
  assign osc_trim = s_q.osc_trim;
  assign i_offset_readback = s_q.cal_i;
  assign q_offset_readback = s_q.cal_q;
  assign dac_i_code = s_q.dac_i;
  assign dac_q_code = s_q.dac_q;
  assign dac_range_bit0 = s_q.cfg.correction_dac_range[0];
  assign dac_range_bit1 = s_q.cfg.correction_dac_range[1];
  assign detector_resistor_bypass = s_q.cfg.detector_resistor_bypass;
  assign detector_capacitor_bypass = s_q.cfg.detector_capacitor_bypass;

  // Readback word, other fields read zero
  always_comb begin
    readback_word = 32'h0;
    readback_word[`DCOC_RB_Q_LSB +: 8] = s_q.cal_q;
    readback_word[`DCOC_RB_I_LSB +: 8] = s_q.cal_i;
  end

  // Helper: calibration clock cycles seen in the current run
  logic [3:0] run_ticks;
  always_ff @(posedge ref_clk) begin
    if (!reset_n || cal_start_set) begin
      run_ticks <= 4'h0;
    end else if (s_q.calibration_start && cal_en) begin
      run_ticks <= 4'(run_ticks + 4'h1);
    end
  end

  a_reset_half_scale: assert property (@(posedge ref_clk)
    $rose(reset_n) |-> i_offset_readback == 8'h80 && q_offset_readback == 8'h80
      && dac_i_code == 8'h80 && dac_q_code == 8'h80)
    else $error("codes not half scale after reset");

  a_trim_reset_value: assert property (@(posedge ref_clk)
    $rose(reset_n) |-> osc_trim == 3'h3)
    else $error("trim not at 900 kHz code after reset");

  a_start_sets_bit: assert property (@(posedge ref_clk) disable iff (!reset_n)
    cal_start_set |=> calibration_start && s_q.state == DCOC_LOAD)
    else $error("start write not taken");

  a_clear_after_nine: assert property (@(posedge ref_clk) disable iff (!reset_n)
    $fell(calibration_start) |-> run_ticks == 4'(`DCOC_CAL_CYCLES))
    else $error("calibration did not take nine cycles");

  a_hold_when_idle: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !calibration_start && !$past(calibration_start) && $past(reset_n)
      |-> $stable(i_offset_readback) && $stable(q_offset_readback))
    else $error("codes changed outside calibration");

  a_step_on_tick: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !cal_en && !cal_start_set && s_q.state == DCOC_STEP |=> $stable(s_q.bit_idx))
    else $error("sequencer moved without calibration clock");

  a_source_select: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !cfg_in.cal_clk_sel && !serial_rise |=> !cal_en)
    else $error("oscillator ticked while serial clock selected");

  a_dac_from_auto: assert property (@(posedge ref_clk) disable iff (!reset_n)
    cfg_in.auto_mode && $stable(cfg_in.auto_mode) |=> dac_i_code == i_offset_readback
      && dac_q_code == q_offset_readback)
    else $error("auto mode DAC not from calibration registers");

  a_manual_values: assert property (@(posedge ref_clk) disable iff (!reset_n)
    manual_wr && !cfg_in.auto_mode |=> dac_i_code == $past(i_channel_correction_value))
    else $error("manual value not driven");

  a_range_follows: assert property (@(posedge ref_clk) disable iff (!reset_n)
    ##1 {dac_range_bit1, dac_range_bit0} == $past(cfg_in.correction_dac_range))
    else $error("DAC range not applied");

  a_bypass_follows: assert property (@(posedge ref_clk) disable iff (!reset_n)
    ##1 detector_resistor_bypass == $past(cfg_in.detector_resistor_bypass)
      && detector_capacitor_bypass == $past(cfg_in.detector_capacitor_bypass))
    else $error("filter bypass not applied");

  a_readback_fields: assert property (@(posedge ref_clk) disable iff (!reset_n)
    cal_en && s_q.state == DCOC_LOAD |=> readback_word[31:16] == 16'h8080)
    else $error("readback not half scale at load");

  // Host control checks
  a_trim_write_taken: assert property (@(posedge ref_clk) disable iff (!reset_n)
    osc_trim_wr |=> osc_trim == $past(osc_trim_value))
    else $error("trim write not taken");

  a_trim_held: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !osc_trim_wr |=> $stable(osc_trim))
    else $error("trim changed without a write");

  a_dac_from_manual: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !cfg_in.auto_mode |=> dac_i_code == s_q.man_i && dac_q_code == s_q.man_q)
    else $error("manual mode DAC not from host values");

  // Clock source and sequencer checks
  a_osc_source: assert property (@(posedge ref_clk) disable iff (!reset_n)
    cfg_in.cal_clk_sel && !osc_tick |=> !cal_en)
    else $error("serial clock ticked while oscillator selected");

  a_start_held: assert property (@(posedge ref_clk) disable iff (!reset_n)
    calibration_start && !(cal_en && s_q.state == DCOC_STEP && s_q.bit_idx == 3'h0)
      |=> calibration_start)
    else $error("start bit cleared before the run ended");

  a_clear_at_end: assert property (@(posedge ref_clk) disable iff (!reset_n)
    cal_en && s_q.state == DCOC_STEP && s_q.bit_idx == 3'h0 && !cal_start_set
      |=> !calibration_start && s_q.state == DCOC_IDLE)
    else $error("start bit not cleared at the end of the run");

  a_idle_no_start: assert property (@(posedge ref_clk) disable iff (!reset_n)
    s_q.state == DCOC_IDLE |-> !calibration_start)
    else $error("start bit high while sequencer idle");

  a_i_step_clears: assert property (@(posedge ref_clk) disable iff (!reset_n)
    cal_en && s_q.state == DCOC_STEP && s_q.det_s2[0] |=> !i_offset_readback[$past(s_q.bit_idx)])
    else $error("I trial bit kept although detector high");

  a_q_step_clears: assert property (@(posedge ref_clk) disable iff (!reset_n)
    cal_en && s_q.state == DCOC_STEP && s_q.det_s2[1] |=> !q_offset_readback[$past(s_q.bit_idx)])
    else $error("Q trial bit kept although detector high");

endmodule

// file: verif/dcoc_det_model.sv
// Offset detector model that drives the comparator pins of the calibration block
`timescale 1ns/1ps
module dcoc_det_model (
  // Correction codes applied to the baseband paths
  input wire logic [7:0] dac_i_code,
  input wire logic [7:0] dac_q_code,
  // Offsets the correction has to cancel
  input wire logic [7:0] target_i,
  input wire logic [7:0] target_q,
  // Comparator outputs, high when the code is too big
  output logic det_i_high,
  output logic det_q_high
);
  // The LO is taken as always applied, so the detector output is always valid
  assign det_i_high = dac_i_code > target_i;
  assign det_q_high = dac_q_code > target_q;
endmodule

// file: verif/dcoc_autocal_tb.sv
// Self-checking bench of the dc offset calibration controller
`timescale 1ns/1ps
module dcoc_autocal_tb
  import dcoc_pkg::*;
;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  dcoc_cfg_type cfg_in = '0;
  logic osc_trim_wr = 1'b0;
  logic cal_start_set = 1'b0;
  logic manual_wr = 1'b0;
  logic serial_clk = 1'b0;
  logic [2:0] osc_trim_value = 3'h0;
  logic [7:0] man_i = 8'h00;
  logic [7:0] man_q = 8'h00;
  logic [7:0] tgt_i = 8'h00;
  logic [7:0] tgt_q = 8'h00;
  logic [7:0] last_i;
  logic [7:0] last_q;
  logic det_i_high, det_q_high, calibration_start, rb0, rb1, rbyp, cbyp;
  logic start_seen = 1'b0;
  logic [2:0] osc_trim;
  logic [7:0] i_rb, q_rb, dac_i_code, dac_q_code;
  logic [31:0] readback_word;
  logic [15:0] note;
  logic [15:0] exp_q[$];
  int khz[8] = '{300, 500, 700, 900, 1100, 1300, 1500, 1800};
  int rat[8] = '{1, 2, 8, 32, 64, 256, 512, 1024};
  int errors = 0;
  int checks = 0;
  int n;
  int rises;
  int steps;

  // Design and detector
  dcoc_autocal dcoc_autocal_i (.ref_clk(ref_clk), .reset_n(reset_n), .cfg_in(cfg_in),
    .osc_trim_wr(osc_trim_wr), .osc_trim_value(osc_trim_value),
    .cal_start_set(cal_start_set), .manual_wr(manual_wr),
    .i_channel_correction_value(man_i), .q_channel_correction_value(man_q),
    .serial_clk(serial_clk), .det_i_high(det_i_high), .det_q_high(det_q_high),
    .calibration_start(calibration_start), .osc_trim(osc_trim),
    .i_offset_readback(i_rb), .q_offset_readback(q_rb), .readback_word(readback_word),
    .dac_i_code(dac_i_code), .dac_q_code(dac_q_code), .dac_range_bit0(rb0),
    .dac_range_bit1(rb1), .detector_resistor_bypass(rbyp),
    .detector_capacitor_bypass(cbyp));
  dcoc_det_model dcoc_det_model_i (.dac_i_code(dac_i_code), .dac_q_code(dac_q_code),
    .target_i(tgt_i), .target_q(tgt_q), .det_i_high(det_i_high), .det_q_high(det_q_high));

  // 125 MHz clock
  always #4 ref_clk = ~ref_clk;

  // Compare one value and count it
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Print the counts and the verdict, then stop
  task automatic end_of_test();
    $display("counts: checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Advance to a later falling edge
  task automatic tick(input int k);
    repeat (k) @(negedge ref_clk);
  endtask

  // Pick new offsets, note the codes they must give, pulse the start bit
  task automatic start_cal();
    tgt_i = 8'($urandom);
    tgt_q = 8'($urandom);
    last_i = tgt_i;
    last_q = tgt_q;
    exp_q.push_back({tgt_i, tgt_q});
    cal_start_set = 1'b1;
    tick(1);
    cal_start_set = 1'b0;
    tick(1);
  endtask

  // Bounded wait for the start bit to clear
  task automatic wait_done(input int lim, output int cyc);
    cyc = 0;
    while (calibration_start !== 1'b0 && cyc < lim) begin
      tick(1);
      cyc++;
    end
    if (cyc >= lim) begin
      errors++;
      $display("unexpected at %0t: calibration did not finish", $time);
      end_of_test();
    end
  endtask

  // One calibration on the internal oscillator with given trim and divider codes
  task automatic run(input int t, input int d);
    int p;
    int cyc;
    p = 125000 / khz[t];
    osc_trim_value = 3'(t);
    osc_trim_wr = 1'b1;
    tick(1);
    osc_trim_wr = 1'b0;
    cfg_in.clk_div_code = 3'(d);
    tick(1);
    chk(32'(osc_trim), t, "trim");
    start_cal();
    chk(32'(calibration_start), 1, "start bit");
    wait_done(9 * rat[d] * p + 50, cyc);
    n = 32'(cyc >= (9 * rat[d] - 1) * p - 2 && cyc <= 9 * rat[d] * p + 8);
    chk(n, 1, "duration");
    $display("test trim %0d div %0d done", t, d);
  endtask

  // Check the final codes against the oldest note whenever the start bit clears
  always @(negedge ref_clk) begin
    if (start_seen && calibration_start === 1'b0) begin
      if (exp_q.size() == 0) begin
        errors++;
        $display("unexpected at %0t: calibration end with no note", $time);
      end else begin
        note = exp_q.pop_front();
        chk({i_rb, q_rb}, note, "cal codes");
        chk(readback_word, {note, 16'h0000}, "readback");
        chk({dac_i_code, dac_q_code}, note, "auto dac");
      end
    end
    start_seen = calibration_start;
  end

  // Main sequence
  initial begin
    n = $urandom(71253);
    tick(5);
    reset_n = 1'b1;
    tick(1);
    chk(32'(calibration_start), 0, "reset start");
    chk(32'(osc_trim), 3, "reset trim");
    chk({i_rb, q_rb, dac_i_code, dac_q_code}, 32'h80808080, "reset codes");
    chk(readback_word, 32'h80800000, "reset readback");
    $display("test reset done");
    // Range and filter bypass copies for every range code
    for (int k = 0; k < 4; k++) begin
      cfg_in.correction_dac_range = 2'(k);
      cfg_in.detector_resistor_bypass = 1'($urandom);
      cfg_in.detector_capacitor_bypass = 1'($urandom);
      tick(2);
      chk({rb1, rb0}, k, "range");
      chk({rbyp, cbyp}, {cfg_in.detector_resistor_bypass,
        cfg_in.detector_capacitor_bypass}, "bypass");
    end
    $display("test config done");
    cfg_in.cal_clk_sel = 1'b1;
    cfg_in.detector_resistor_bypass = 1'b1;
    cfg_in.detector_capacitor_bypass = 1'b1;
    cfg_in.auto_mode = 1'b1;
    for (int t = 0; t < 8; t++) begin
      run(t, 0);
    end
    for (int d = 1; d < 4; d++) begin
      run(7, d);
    end
    // Codes hold when the offsets move and no calibration is started
    tgt_i = ~last_i;
    tgt_q = ~last_q;
    tick(50);
    chk({i_rb, q_rb, dac_i_code}, {last_i, last_q, last_i}, "held");
    // Manual values drive the DACs only while automatic mode is off
    cfg_in.auto_mode = 1'b0;
    man_i = 8'($urandom);
    man_q = 8'($urandom);
    manual_wr = 1'b1;
    tick(1);
    manual_wr = 1'b0;
    tick(2);
    chk({dac_i_code, dac_q_code}, {man_i, man_q}, "manual dac");
    chk({i_rb, q_rb}, {last_i, last_q}, "cal kept");
    cfg_in.auto_mode = 1'b1;
    tick(2);
    chk({dac_i_code, dac_q_code}, {last_i, last_q}, "auto again");
    $display("test manual done");
    // Serial clock as source: no progress while it stands, nine edges finish
    cfg_in.cal_clk_sel = 1'b0;
    cfg_in.clk_div_code = 3'h0;
    tick(1);
    start_cal();
    tick(800);
    chk(32'(calibration_start), 1, "serial idle");
    for (int e = 0; e < 9; e++) begin
      if (e == 8) begin
        tick(10);
        chk(32'(calibration_start), 1, "eight edges");
      end
      serial_clk = 1'b1;
      tick(4);
      serial_clk = 1'b0;
      tick(4);
    end
    wait_done(20, n);
    $display("test serial clock done");
    // Long dividers on a fast serial clock; filter narrowed for the slow ratios
    for (int d = 4; d < 8; d++) begin
      cfg_in.clk_div_code = 3'(d);
      cfg_in.detector_resistor_bypass = 1'(d < 6);
      cfg_in.detector_capacitor_bypass = 1'(d < 6);
      start_cal();
      rises = 0;
      steps = 0;
      while (calibration_start !== 1'b0 && steps < 18 * rat[d] + 40) begin
        serial_clk = ~serial_clk;
        rises += int'(serial_clk);
        tick(1);
        steps++;
      end
      serial_clk = 1'b0;
      wait_done(1, n);
      n = 32'(rises >= 9 * rat[d] && rises <= 9 * rat[d] + 2);
      chk(n, 1, "serial ratio");
      $display("test serial div %0d done", d);
    end
    tick(3);
    chk(exp_q.size(), 0, "notes left");
    end_of_test();
  end
endmodule
